// *** design/uls_defines.svh ***
// bit positions, reset values and counts for the line and modem status block
`ifndef ULS_DEFINES_SVH
`define ULS_DEFINES_SVH

// ----------------------------------------------------------------------
// line status bit positions
// ----------------------------------------------------------------------
`define ULS_LSR_DATA_READY   0
`define ULS_LSR_OVERRUN      1
`define ULS_LSR_PARITY       2
`define ULS_LSR_FRAMING      3
`define ULS_LSR_BREAK        4
`define ULS_LSR_THR_EMPTY    5
`define ULS_LSR_TX_EMPTY     6
`define ULS_LSR_FIFO_ERR     7

// ----------------------------------------------------------------------
// modem status bit positions
// ----------------------------------------------------------------------
`define ULS_MSR_DELTA_CTS    0
`define ULS_MSR_DELTA_DSR    1
`define ULS_MSR_DELTA_RI     2
`define ULS_MSR_DELTA_CD     3
`define ULS_MSR_CTS          4
`define ULS_MSR_DSR          5
`define ULS_MSR_RI           6
`define ULS_MSR_CD           7

// ----------------------------------------------------------------------
// receive fifo entry layout: data in [7:0], tags above
// ----------------------------------------------------------------------
`define ULS_TAG_PARITY       8
`define ULS_TAG_FRAMING      9
`define ULS_TAG_BREAK        10
`define ULS_ENTRY_WIDTH      11

// ----------------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------------
`define ULS_LSR_RESET        8'h00
`define ULS_MSR_RESET        8'h00
`define ULS_BREAK_CHAR       8'h00
`define ULS_FIFO_DEPTH       64
`define ULS_BREAK_FRAME_TICKS 160

`endif

// *** design/uls_pkg.sv ***
// types shared by the line and modem status block
package uls_pkg;

    // break detector states
    typedef enum logic [1:0] {
        BK_IDLE  = 2'b00,
        BK_COUNT = 2'b01,
        BK_HELD  = 2'b10
    } uls_break_e;

    typedef logic [7:0] uls_byte_t;

endpackage

// *** design/uls_sync.sv ***
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps

module uls_sync #(
    parameter int               WIDTH     = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             reset,
    // pins in, synchronised out
    input  wire logic [WIDTH-1:0] pinIn,
    output logic      [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage1_ff;

    // pins idle high, so reset to the inactive level
    always_ff @(posedge clock) begin
        if (reset) begin
            stage1_ff <= RESET_VAL;
            syncOut   <= RESET_VAL;
        end else begin
            stage1_ff <= pinIn;
            syncOut   <= stage1_ff;
        end
    end

endmodule

// *** design/uls_break_det.sv ***
// break detector: receive line low for a whole character frame
`timescale 1ns/1ps
`include "uls_defines.svh"

module uls_break_det #(
    parameter int FRAME_TICKS = `ULS_BREAK_FRAME_TICKS
) (
    // clock and reset
    input  wire logic clock,
    input  wire logic reset,
    // sampling
    input  wire logic baudTick,
    input  wire logic rxLine,
    // result
    output logic      breakPulse_ff
);
    import uls_pkg::*;

    localparam int CW = $clog2(FRAME_TICKS + 1);

    uls_break_e    state_ff;
    logic [CW-1:0] lowCount_ff;
    logic          frameDone;

    assign frameDone = baudTick && !rxLine &&
                       (lowCount_ff == CW'(FRAME_TICKS - 1));

    // --------------------------------------------------------------
    // state and low-time counter
    // --------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            state_ff    <= BK_IDLE;
            lowCount_ff <= '0;
        end else begin
            unique case (state_ff)
                BK_IDLE: begin
                    lowCount_ff <= '0;
                    if (!rxLine) begin
                        state_ff <= BK_COUNT;
                    end
                end
                BK_COUNT: begin
                    if (rxLine) begin
                        state_ff <= BK_IDLE;
                    end else if (frameDone) begin
                        state_ff <= BK_HELD;
                    end else if (baudTick) begin
                        lowCount_ff <= lowCount_ff + CW'(1);
                    end
                end
                BK_HELD: begin
                    // one break per low stretch; wait for the line to rise
                    if (rxLine) begin
                        state_ff <= BK_IDLE;
                    end
                end
                default: begin
                    state_ff <= BK_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            breakPulse_ff <= 1'b0;
        end else begin
            breakPulse_ff <= (state_ff == BK_COUNT) && frameDone;
        end
    end

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    property p_break_frame;
        @(posedge clock) disable iff (reset)
        (state_ff == BK_COUNT && frameDone) |=> breakPulse_ff ##1
            !breakPulse_ff;
    endproperty
    a_break_frame: assert property (p_break_frame)
        else $error("break not flagged after a full low frame");

endmodule

// *** design/uls_line_modem_status.sv ***
// line status and modem status for one uart channel
//
// Contract
// - fifo error flag high while any tagged character sits in rx fifo
// - transmitter empty only when holding and shift registers are empty
// - holding empty flag follows an empty tx holding register
// - line low a full frame stores 0x00 tagged as break
// - framing bit shows the tag of the next character to read
// - parity bit shows the tag of the next character to read
// - overrun flag set on overrun, zero after reset
// - data ready while at least one character is stored
// - every fifo entry keeps its three tags; status shows the oldest
// - clear-to-send bit is the inverse of the active-low input
// - carrier bit is the inverse of its pin when that pin is selected
// - ring bit is the inverse of its pin when that pin is selected
// - dsr bit is the inverse of its pin when that pin is selected
// - cd, dsr, cts change flags latch either edge, clear on read
// - ring change flag latches only on pin low to high, clears on read
// - loopback routes rts/dtr into cts/dsr and tx into rx
`timescale 1ns/1ps
`include "uls_defines.svh"

module uls_line_modem_status #(
    parameter int DEPTH       = `ULS_FIFO_DEPTH,
    parameter int FRAME_TICKS = `ULS_BREAK_FRAME_TICKS
) (
    // clock and reset
    input  wire logic           clock,
    input  wire logic           reset,
    // receiver character port
    input  wire logic           rxCharValid,
    input  wire uls_pkg::uls_byte_t rxCharData,
    input  wire logic           rxParityErr,
    input  wire logic           rxFramingErr,
    input  wire logic           baudTick,
    // transmitter state
    input  wire logic           txHoldEmpty,
    input  wire logic           txShiftEmpty,
    input  wire logic           txSerial,
    // serial receive pin and line after loopback
    input  wire logic           rxPin,
    output logic                rxLine_ff,
    // modem handshake pins, active low
    input  wire logic           ctsN,
    input  wire logic           dsrN,
    input  wire logic           cdN,
    input  wire logic           riN,
    // configuration from modem control and io config
    input  wire logic           loopbackEn,
    input  wire logic           rtsCtl,
    input  wire logic           dtrCtl,
    input  wire logic           cdPinSel,
    input  wire logic           riPinSel,
    input  wire logic           dsrPinSel,
    // host reads
    input  wire logic           lineStatusRead,
    input  wire logic           modemStatusRead,
    input  wire logic           rxHoldRead,
    output uls_pkg::uls_byte_t  lineStatus_ff,
    output uls_pkg::uls_byte_t  modemStatus_ff,
    output uls_pkg::uls_byte_t  rxHoldData_ff
);
    import uls_pkg::*;

    localparam int AW = $clog2(DEPTH);
    localparam int EW = `ULS_ENTRY_WIDTH;

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [4:0] pinSync;
    logic       ctsSyncN;
    logic       dsrSyncN;
    logic       cdSyncN;
    logic       riSyncN;
    logic       rxSync;

    uls_sync #(
        .WIDTH     (5),
        .RESET_VAL (5'h1F)
    ) u_sync (
        .clock   (clock),
        .reset   (reset),
        .pinIn   ({rxPin, riN, cdN, dsrN, ctsN}),
        .syncOut (pinSync)
    );

    assign ctsSyncN = pinSync[0];
    assign dsrSyncN = pinSync[1];
    assign cdSyncN  = pinSync[2];
    assign riSyncN  = pinSync[3];
    assign rxSync   = pinSync[4];

    // ------------------------------------------------------------------
    // loopback of the serial line
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            rxLine_ff <= 1'b1;
        end else begin
            rxLine_ff <= loopbackEn ? txSerial : rxSync;
        end
    end

    // ------------------------------------------------------------------
    // break detection on the looped line
    // ------------------------------------------------------------------
    logic breakPulse;

    uls_break_det #(
        .FRAME_TICKS (FRAME_TICKS)
    ) u_break (
        .clock         (clock),
        .reset         (reset),
        .baudTick      (baudTick),
        .rxLine        (rxLine_ff),
        .breakPulse_ff (breakPulse)
    );

    // ------------------------------------------------------------------
    // receive fifo with per-entry tags
    // ------------------------------------------------------------------
    logic [EW-1:0] fifoMem [DEPTH];
    logic [AW-1:0] wrPtr_ff;
    logic [AW-1:0] rdPtr_ff;
    logic [AW:0]   fillCount_ff;
    logic [AW:0]   errCount_ff;
    logic          fifoFull;
    logic          fifoEmpty;
    logic          charDone;
    logic          doPush;
    logic          doPop;
    logic [EW-1:0] pushEntry;
    logic [EW-1:0] headEntry;
    logic          pushTagged;
    logic          headTagged;

    assign fifoFull  = (fillCount_ff == (AW+1)'(DEPTH));
    assign fifoEmpty = (fillCount_ff == '0);
    assign doPop     = rxHoldRead && !fifoEmpty;
    assign charDone  = rxCharValid || breakPulse;
    // a pop in the same cycle frees the slot, so no overrun then
    assign doPush    = charDone && (!fifoFull || doPop);
    assign headEntry = fifoMem[rdPtr_ff];

    // a break outranks a receiver character in the same cycle
    always_comb begin
        if (breakPulse) begin
            pushEntry = '0;
            pushEntry[7:0] = `ULS_BREAK_CHAR;
            pushEntry[`ULS_TAG_BREAK] = 1'b1;
        end else begin
            pushEntry = '0;
            pushEntry[7:0] = rxCharData;
            pushEntry[`ULS_TAG_PARITY]  = rxParityErr;
            pushEntry[`ULS_TAG_FRAMING] = rxFramingErr;
        end
    end

    assign pushTagged = |pushEntry[EW-1:8];
    assign headTagged = |headEntry[EW-1:8];

    always_ff @(posedge clock) begin
        if (doPush) begin
            fifoMem[wrPtr_ff] <= pushEntry;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            wrPtr_ff     <= '0;
            rdPtr_ff     <= '0;
            fillCount_ff <= '0;
        end else begin
            if (doPush) begin
                wrPtr_ff <= (wrPtr_ff == AW'(DEPTH - 1)) ? '0
                          : wrPtr_ff + AW'(1);
            end
            if (doPop) begin
                rdPtr_ff <= (rdPtr_ff == AW'(DEPTH - 1)) ? '0
                          : rdPtr_ff + AW'(1);
            end
            if (doPush && !doPop) begin
                fillCount_ff <= fillCount_ff + (AW+1)'(1);
            end else if (doPop && !doPush) begin
                fillCount_ff <= fillCount_ff - (AW+1)'(1);
            end
        end
    end

    // count of tagged entries still stored; avoids scanning all slots
    always_ff @(posedge clock) begin
        if (reset) begin
            errCount_ff <= '0;
        end else begin
            unique case ({doPush && pushTagged, doPop && headTagged})
                2'b10:   errCount_ff <= errCount_ff + (AW+1)'(1);
                2'b01:   errCount_ff <= errCount_ff - (AW+1)'(1);
                2'b00,
                2'b11:   errCount_ff <= errCount_ff;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // overrun flag
    // ------------------------------------------------------------------
    logic overrun_ff;
    logic overrunEvent;

    assign overrunEvent = charDone && fifoFull && !doPop;

    // a new overrun in the read cycle survives the clear
    always_ff @(posedge clock) begin
        if (reset) begin
            overrun_ff <= 1'b0;
        end else begin
            overrun_ff <= (overrun_ff && !lineStatusRead)
                        || overrunEvent;
        end
    end

    // ------------------------------------------------------------------
    // line status and receive holding register
    // ------------------------------------------------------------------
    uls_byte_t nxt_lineStatus;

    always_comb begin
        nxt_lineStatus = `ULS_LSR_RESET;
        nxt_lineStatus[`ULS_LSR_DATA_READY] = !fifoEmpty;
        nxt_lineStatus[`ULS_LSR_OVERRUN]    = overrun_ff;
        nxt_lineStatus[`ULS_LSR_PARITY]     =
            !fifoEmpty && headEntry[`ULS_TAG_PARITY];
        nxt_lineStatus[`ULS_LSR_FRAMING]    =
            !fifoEmpty && headEntry[`ULS_TAG_FRAMING];
        nxt_lineStatus[`ULS_LSR_BREAK]      =
            !fifoEmpty && headEntry[`ULS_TAG_BREAK];
        nxt_lineStatus[`ULS_LSR_THR_EMPTY]  = txHoldEmpty;
        nxt_lineStatus[`ULS_LSR_TX_EMPTY]   =
            txHoldEmpty && txShiftEmpty;
        nxt_lineStatus[`ULS_LSR_FIFO_ERR]   = (errCount_ff != '0);
    end

    // tags and data of the same head entry are presented together, so
    // reading status first and the holding register next pairs them
    always_ff @(posedge clock) begin
        if (reset) begin
            lineStatus_ff <= `ULS_LSR_RESET;
            rxHoldData_ff <= 8'h00;
        end else begin
            lineStatus_ff <= nxt_lineStatus;
            rxHoldData_ff <= fifoEmpty ? 8'h00 : headEntry[7:0];
        end
    end

    // ------------------------------------------------------------------
    // modem input levels, active high after inversion
    // ------------------------------------------------------------------
    logic ctsLvl;
    logic dsrLvl;
    logic cdLvl;
    logic riLvl;

    // inputs are active low on the pins
    assign ctsLvl = loopbackEn ? rtsCtl : !ctsSyncN;
    assign dsrLvl = loopbackEn ? dtrCtl
                  : (dsrPinSel && !dsrSyncN);
    assign cdLvl  = cdPinSel && !cdSyncN;
    assign riLvl  = riPinSel && !riSyncN;

    // ------------------------------------------------------------------
    // change detection
    // ------------------------------------------------------------------
    logic ctsPrev_ff;
    logic dsrPrev_ff;
    logic cdPrev_ff;
    logic riPrev_ff;
    logic deltaCts_ff;
    logic deltaDsr_ff;
    logic deltaCd_ff;
    logic deltaRi_ff;

    always_ff @(posedge clock) begin
        if (reset) begin
            ctsPrev_ff <= 1'b0;
            dsrPrev_ff <= 1'b0;
            cdPrev_ff  <= 1'b0;
            riPrev_ff  <= 1'b0;
        end else begin
            ctsPrev_ff <= ctsLvl;
            dsrPrev_ff <= dsrLvl;
            cdPrev_ff  <= cdLvl;
            riPrev_ff  <= riLvl;
        end
    end

    // set wins over the clear of a status read in the same cycle
    always_ff @(posedge clock) begin
        if (reset) begin
            deltaCts_ff <= 1'b0;
            deltaDsr_ff <= 1'b0;
            deltaCd_ff  <= 1'b0;
            deltaRi_ff  <= 1'b0;
        end else begin
            deltaCts_ff <= (deltaCts_ff && !modemStatusRead)
                         || (ctsLvl != ctsPrev_ff);
            deltaDsr_ff <= (deltaDsr_ff && !modemStatusRead)
                         || (dsrLvl != dsrPrev_ff);
            deltaCd_ff  <= (deltaCd_ff && !modemStatusRead)
                         || (cdLvl != cdPrev_ff);
            // pin low to high is the status level falling
            deltaRi_ff  <= (deltaRi_ff && !modemStatusRead)
                         || (riPrev_ff && !riLvl);
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            modemStatus_ff <= `ULS_MSR_RESET;
        end else begin
            modemStatus_ff <= {cdLvl, riLvl, dsrLvl, ctsLvl,
                               deltaCd_ff, deltaRi_ff,
                               deltaDsr_ff, deltaCts_ff};
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_fifo_err;
        @(posedge clock) disable iff (reset)
        (errCount_ff != '0) |=> lineStatus_ff[`ULS_LSR_FIFO_ERR];
    endproperty
    a_fifo_err: assert property (p_fifo_err)
        else $error("fifo error flag low while errors are stored");

    property p_tx_empty;
        @(posedge clock) disable iff (reset)
        !(txHoldEmpty && txShiftEmpty) |=>
            !lineStatus_ff[`ULS_LSR_TX_EMPTY];
    endproperty
    a_tx_empty: assert property (p_tx_empty)
        else $error("transmitter empty shown while data remains");

    property p_thr_empty;
        @(posedge clock) disable iff (reset)
        txHoldEmpty |=> lineStatus_ff[`ULS_LSR_THR_EMPTY];
    endproperty
    a_thr_empty: assert property (p_thr_empty)
        else $error("holding empty flag missing");

    property p_break_push;
        @(posedge clock) disable iff (reset)
        (breakPulse && fifoEmpty) |=> ##1
            (lineStatus_ff[`ULS_LSR_BREAK] && rxHoldData_ff == 8'h00);
    endproperty
    a_break_push: assert property (p_break_push)
        else $error("break character not stored with its tag");

    property p_overrun;
        @(posedge clock) disable iff (reset)
        overrunEvent |-> ##2 lineStatus_ff[`ULS_LSR_OVERRUN];
    endproperty
    a_overrun: assert property (p_overrun)
        else $error("overrun not reported");

    property p_data_ready;
        @(posedge clock) disable iff (reset)
        fifoEmpty |=> !lineStatus_ff[`ULS_LSR_DATA_READY];
    endproperty
    a_data_ready: assert property (p_data_ready)
        else $error("data ready shown with an empty fifo");

    property p_cts_level;
        @(posedge clock) disable iff (reset)
        (!loopbackEn && !ctsSyncN) |=> modemStatus_ff[`ULS_MSR_CTS];
    endproperty
    a_cts_level: assert property (p_cts_level)
        else $error("cts bit is not the inverse of the pin");

    property p_loop_rts;
        @(posedge clock) disable iff (reset)
        (loopbackEn && rtsCtl) |=> modemStatus_ff[`ULS_MSR_CTS];
    endproperty
    a_loop_rts: assert property (p_loop_rts)
        else $error("loopback rts not seen on cts bit");

    property p_delta_cts;
        @(posedge clock) disable iff (reset)
        (ctsLvl != ctsPrev_ff) |=> ##1 modemStatus_ff[`ULS_MSR_DELTA_CTS];
    endproperty
    a_delta_cts: assert property (p_delta_cts)
        else $error("cts change not latched");

    property p_delta_ri;
        @(posedge clock) disable iff (reset)
        (!riPrev_ff && riLvl && !deltaRi_ff) |=> !deltaRi_ff;
    endproperty
    a_delta_ri: assert property (p_delta_ri)
        else $error("ring change latched on the wrong edge");

    c_overrun:  cover property (@(posedge clock) disable iff (reset)
                                overrunEvent);
    c_break:    cover property (@(posedge clock) disable iff (reset)
                                breakPulse);
    c_msr_read: cover property (@(posedge clock) disable iff (reset)
                                deltaCd_ff && modemStatusRead);

endmodule

// *** tb/uls_modem_model.sv ***
// modem side model driving the active-low handshake pins
`timescale 1ns/1ps

module uls_modem_model (
    // asserted levels: cts dsr cd ri
    input  wire logic [3:0] assertLines,
    // active-low pins
    output logic            ctsN,
    output logic            dsrN,
    output logic            cdN,
    output logic            riN
);
    // a peripheral asserts a handshake by pulling its pin low
    assign {ctsN, dsrN, cdN, riN} = ~assertLines;
endmodule

// *** tb/uls_line_modem_status_tb.sv ***
// testbench for the line and modem status block
`timescale 1ns/1ps

module uls_line_modem_status_tb;
    import uls_pkg::*;
    logic clock = 0, reset = 1, rxCharValid = 0, rxParityErr = 0;
    logic rxFramingErr = 0, baudTick = 0, txHoldEmpty = 0;
    logic txShiftEmpty = 0, txSerial = 1, rxPin = 1, loopbackEn = 0;
    logic rtsCtl = 0, dtrCtl = 0, cdPinSel = 1, riPinSel = 1;
    logic dsrPinSel = 1, lineStatusRead = 0, modemStatusRead = 0;
    logic rxHoldRead = 0, ctsN, dsrN, cdN, riN, rxLine_ff;
    logic [3:0] mdm = 0;
    uls_byte_t rxCharData = 0, lineStatus_ff, modemStatus_ff;
    uls_byte_t rxHoldData_ff;
    int mismatches = 0;
    int tests_run = 0;

    always #4 clock = ~clock;

    uls_line_modem_status #(.DEPTH(4), .FRAME_TICKS(8))
        uls_line_modem_status_i (.*);
    uls_modem_model uls_modem_model_i (.assertLines(mdm), .ctsN(ctsN),
        .dsrN(dsrN), .cdN(cdN), .riN(riN));

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    // inputs move 1 ns after the edge so the design never races them
    task cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task chk(input uls_byte_t got, input uls_byte_t exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // strobe selectors for pulse; one strobe high for one cycle
    localparam int LS_RD = 0, MS_RD = 1, HOLD_RD = 2, TICK = 3;
    task pulse(input int sel);
        {baudTick, rxHoldRead, modemStatusRead, lineStatusRead} = 4'(1 << sel);
        cyc(1);
        {baudTick, rxHoldRead, modemStatusRead, lineStatusRead} = 4'h0;
        cyc(1);
    endtask
    // valid stays high across back-to-back pushes; caller lowers it
    task push(input uls_byte_t d, input logic p, input logic f);
        rxCharData = d;
        {rxParityErr, rxFramingErr, rxCharValid} = {p, f, 1'b1};
        cyc(1);
    endtask
    task results;
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        #100000;
        mismatches++;
        results;
    end

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        cyc(3);
        reset = 0;
        cyc(3);
        chk(lineStatus_ff, 8'h00);
        pulse(MS_RD);
        mdm = 4'b1000;
        cyc(5);
        chk(modemStatus_ff, 8'h11);
        pulse(MS_RD);
        cyc(1);
        chk(modemStatus_ff, 8'h10);
        mdm = 4'b1111;
        cyc(5);
        chk(modemStatus_ff, 8'hFA);
        pulse(MS_RD);
        mdm = 4'b0000;
        cyc(5);
        chk(modemStatus_ff, 8'h0F);
        {loopbackEn, rtsCtl, dtrCtl, txSerial} = 4'b1110;
        cyc(5);
        chk(modemStatus_ff & 8'h30, 8'h30);
        chk({7'h0, rxLine_ff}, 8'h00);
        // pins asserted but not selected as modem inputs read as zero
        {loopbackEn, txSerial, cdPinSel, riPinSel, dsrPinSel} = 5'b01000;
        mdm = 4'b0111;
        cyc(5);
        chk(modemStatus_ff & 8'hE0, 8'h00);
        txHoldEmpty = 1;
        cyc(2);
        chk(lineStatus_ff, 8'h20);
        txShiftEmpty = 1;
        cyc(2);
        chk(lineStatus_ff, 8'h60);
        {txHoldEmpty, txShiftEmpty} = 2'b00;
        // back-to-back characters carrying different tags
        push(8'h5A, 1, 0);
        push(8'hC3, 0, 1);
        rxCharValid = 0;
        cyc(2);
        chk(lineStatus_ff, 8'h85);
        chk(rxHoldData_ff, 8'h5A);
        pulse(HOLD_RD);
        cyc(1);
        chk(lineStatus_ff, 8'h89);
        chk(rxHoldData_ff, 8'hC3);
        pulse(HOLD_RD);
        cyc(1);
        chk(lineStatus_ff, 8'h00);
        // five characters into a four-deep fifo: the last is lost
        for (int i = 0; i < 5; i++) push(8'h10 + 8'(i), 0, 0);
        rxCharValid = 0;
        cyc(2);
        chk(lineStatus_ff, 8'h03);
        pulse(LS_RD);
        cyc(1);
        chk(lineStatus_ff, 8'h01);
        chk(rxHoldData_ff, 8'h10);
        repeat (4) pulse(HOLD_RD);
        cyc(1);
        chk(lineStatus_ff, 8'h00);
        // line held low for a whole frame of ticks
        rxPin = 0;
        cyc(4);
        repeat (8) pulse(TICK);
        rxPin = 1;
        cyc(3);
        chk(lineStatus_ff, 8'h91);
        chk(rxHoldData_ff, 8'h00);
        results;
    end
endmodule
